/* bench/ctrl_model.sv */
`timescale 1ns/10ps
module ctrl_model
  import motor_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bench request: op enable, no quick, no coast, on
  input wire logic [3:0] req_in,
  // Motor feedback
  input wire logic energise_in,
  input wire logic ramp_down_in,
  input wire logic quick_ramp_in,
  // Towards the sequencer
  output logic [CW_W-1:0] ctrl_word_out,
  output logic zero_speed_out
);
  logic [4:0] spd_ff;

  always_comb begin
    ctrl_word_out = '0;
    ctrl_word_out[CW_ON] = req_in[0];
    ctrl_word_out[CW_NO_COAST] = req_in[1];
    ctrl_word_out[CW_NO_QUICK] = req_in[2];
    ctrl_word_out[CW_OP_ENABLE] = req_in[3];
  end

  // Crude motor speed: quick ramp falls three times faster
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !energise_in) begin
      spd_ff <= 5'h00;
    end else if (quick_ramp_in) begin
      spd_ff <= (spd_ff > 5'h03) ? spd_ff - 5'h03 : 5'h00;
    end else if (ramp_down_in) begin
      spd_ff <= (spd_ff > 5'h00) ? spd_ff - 5'h01 : 5'h00;
    end else if (spd_ff < 5'h0c) begin
      spd_ff <= spd_ff + 5'h01;
    end
  end

  assign zero_speed_out = (spd_ff == 5'h00);
endmodule

/* bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import motor_seq_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic auto_start = 1'b0;
  scheme_t scheme = SCHEME_FIELDBUS;
  logic [3:0] req = 4'h6;
  logic [DI_W-1:0] di = 3'h0;
  logic coast_n = 1'b1;
  logic [CW_W-1:0] ctrl_word;
  logic zero_speed;
  seq_state_t state_out;
  logic energise, ramp_down, quick_ramp, reverse;
  int err_count = 0;
  int n_tests = 0;
  scheme_t sch_tab[5] = '{SCHEME_TWO_WIRE_1, SCHEME_TWO_WIRE_2, SCHEME_TWO_WIRE_3,
    SCHEME_THREE_WIRE_1, SCHEME_THREE_WIRE_2};
  logic [2:0] run_tab[5] = '{3'h3, 3'h2, 3'h4, 3'h5, 3'h7};
  logic [2:0] stop_tab[5] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
  logic rev_tab[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  motor_switch_sequencer motor_switch_sequencer_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .scheme_in(scheme),
    .auto_start_in(auto_start), .di_op_enable_in(1'b1), .di_in(di),
    .di_coast_stop_n_in(coast_n), .di_quick_stop_n_in(1'b1),
    .ctrl_word_in(ctrl_word), .zero_speed_in(zero_speed), .state_out(state_out),
    .energise_out(energise), .ramp_down_out(ramp_down),
    .quick_ramp_out(quick_ramp), .reverse_out(reverse));

  ctrl_model ctrl_model_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .energise_in(energise),
    .ramp_down_in(ramp_down), .quick_ramp_in(quick_ramp),
    .ctrl_word_out(ctrl_word), .zero_speed_out(zero_speed));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wait_st(input seq_state_t exp);
    int i;
    i = 0;
    while (state_out !== exp && i < 60) begin
      @(negedge clk_in);
      i++;
    end
    check("state", 8'(state_out), 8'(exp));
  endtask

  task automatic do_reset(input logic as);
    @(negedge clk_in);
    auto_start = as;
    rst_n_in = 1'b0;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic set_req(input logic [3:0] r);
    @(negedge clk_in);
    req = r;
  endtask

  task automatic to_op();
    set_req(4'hf);
    wait_st(operation_state);
    check("energise", 8'(energise), 8'h01);
    repeat (12) @(negedge clk_in);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #40000;
    err_count++;
    report_and_stop();
  end

  initial begin
    do_reset(1'b0);
    check("state", 8'(state_out), 8'(ready_to_switch_on_state));
    set_req(4'h7);
    wait_st(ready_state);
    repeat (6) @(negedge clk_in);
    check("state", 8'(state_out), 8'(ready_state));
    to_op();
    set_req(4'he);
    wait_st(normal_stop_state);
    check("ramp_down", 8'(ramp_down), 8'h01);
    check("energise", 8'(energise), 8'h01);
    wait_st(ready_to_switch_on_state);
    check("energise", 8'(energise), 8'h00);
    $display("test stop_ramp done");
    to_op();
    set_req(4'hb);
    wait_st(fast_stop_state);
    check("quick_ramp", 8'(quick_ramp), 8'h01);
    wait_st(switch_on_inhibited_state);
    set_req(4'hf);
    repeat (8) @(negedge clk_in);
    check("state", 8'(state_out), 8'(switch_on_inhibited_state));
    set_req(4'h6);
    wait_st(ready_to_switch_on_state);
    $display("test quick_stop done");
    to_op();
    set_req(4'hd);
    wait_st(switch_on_inhibited_state);
    check("energise", 8'(energise), 8'h00);
    set_req(4'h6);
    wait_st(ready_to_switch_on_state);
    to_op();
    set_req(4'h8);
    repeat (3) @(negedge clk_in);
    check("energise", 8'(energise), 8'h00);
    check("quick_ramp", 8'(quick_ramp), 8'h00);
    set_req(4'h6);
    wait_st(ready_to_switch_on_state);
    $display("test coast_stop done");
    for (int k = 0; k < 5; k++) begin
      @(negedge clk_in);
      scheme = sch_tab[k];
      di = run_tab[k];
      wait_st(operation_state);
      check("reverse", 8'(reverse), 8'(rev_tab[k]));
      repeat (12) @(negedge clk_in);
      if (k == 4) begin
        coast_n = 1'b0;
        wait_st(switch_on_inhibited_state);
        coast_n = 1'b1;
      end
      di = stop_tab[k];
      if (k < 4) begin
        wait_st(normal_stop_state);
      end
      wait_st(ready_to_switch_on_state);
    end
    $display("test schemes done");
    scheme = SCHEME_FIELDBUS;
    req = 4'hf;
    do_reset(1'b0);
    check("state", 8'(state_out), 8'(switch_on_inhibited_state));
    do_reset(1'b1);
    wait_st(operation_state);
    $display("test boot done");
    report_and_stop();
  end
endmodule

/* core/motor_cmd_decode.sv */
`timescale 1ns/10ps
module motor_cmd_decode
  import motor_seq_pkg::*;
(
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Configuration
  input wire scheme_t scheme_in,
  input wire logic di_op_enable_in,
  input wire logic zero_speed_in,
  // Sources; pin inputs already synchronised, control word taken directly
  input wire logic [DI_W-1:0] di_in,
  input wire logic [CW_W-1:0] ctrl_word_in,
  input wire logic di_coast_stop_n_in,
  input wire logic di_quick_stop_n_in,
  // Decoded commands
  motor_cmd_if.src cmd
);

  logic [1:0] latch_ff;
  logic [1:0] first_ff;
  logic a;
  logic b;
  logic en;
  logic fb;

  assign a = di_in[DI_CMD_A];
  assign b = di_in[DI_CMD_B];
  assign en = di_in[DI_ENABLE];
  assign fb = (scheme_in == SCHEME_FIELDBUS);

  // Three-wire latch of direction push-buttons; first-wins memory for method 2
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      latch_ff <= CMD_NONE;
      first_ff <= CMD_NONE;
    end else if (ce_in) begin
      if (!en) begin
        latch_ff <= CMD_NONE;
      end else if (scheme_in == SCHEME_THREE_WIRE_2) begin
        // Only the switch-on input latches; the other one only reverses
        if (a) begin
          latch_ff <= CMD_CW;
        end
      end else if (a && !b) begin
        latch_ff <= CMD_CW;
      end else if (b && !a) begin
        latch_ff <= CMD_CCW;
      end
      if (!a && !b) begin
        first_ff <= CMD_NONE;
      end else if (zero_speed_in || first_ff == CMD_NONE) begin
        first_ff <= (a && !(first_ff == CMD_CCW && b)) ? CMD_CW : CMD_CCW;
      end
    end
  end

  always_comb begin
    cmd.run = 1'b0;
    cmd.reverse = 1'b0;
    case (scheme_in)
      SCHEME_TWO_WIRE_1: begin
        cmd.run = di_in[DI_ENABLE];
        cmd.reverse = a;
      end
      SCHEME_TWO_WIRE_2: begin
        cmd.run = a || b;
        cmd.reverse = (first_ff == CMD_CCW);
      end
      SCHEME_TWO_WIRE_3: begin
        cmd.run = a ^ b;
        cmd.reverse = b && !a;
      end
      SCHEME_THREE_WIRE_1: begin
        cmd.run = en && (latch_ff != CMD_NONE);
        cmd.reverse = (latch_ff == CMD_CCW);
      end
      SCHEME_THREE_WIRE_2: begin
        cmd.run = en && (latch_ff != CMD_NONE);
        cmd.reverse = b;
      end
      SCHEME_FIELDBUS: begin
        cmd.run = ctrl_word_in[CW_ON];
        cmd.reverse = ctrl_word_in[CW_REVERSE];
      end
      default: begin
        cmd.run = 1'b0;
        cmd.reverse = 1'b0;
      end
    endcase
  end

  // Fieldbus enable comes from the control word; terminals use a default-high setting
  assign cmd.op_enable = fb ? ctrl_word_in[CW_OP_ENABLE] : di_op_enable_in;
  assign cmd.coast_stop = !di_coast_stop_n_in || (fb && !ctrl_word_in[CW_NO_COAST]);
  assign cmd.quick_stop = !di_quick_stop_n_in || (fb && !ctrl_word_in[CW_NO_QUICK]);

endmodule

/* core/motor_cmd_if.sv */
`timescale 1ns/10ps
interface motor_cmd_if;
  logic run;
  logic reverse;
  logic op_enable;
  logic coast_stop;
  logic quick_stop;
  modport src (output run, output reverse, output op_enable, output coast_stop,
    output quick_stop);
  modport dst (input run, input reverse, input op_enable, input coast_stop,
    input quick_stop);
endinterface

/* core/motor_input_sync.sv */
`timescale 1ns/10ps
module motor_input_sync
  import motor_seq_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce_in) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* core/motor_seq_pkg.sv */
package motor_seq_pkg;

  // Command source and digital-input scheme selection
  typedef enum logic [2:0] {
    SCHEME_TWO_WIRE_1,
    SCHEME_TWO_WIRE_2,
    SCHEME_TWO_WIRE_3,
    SCHEME_THREE_WIRE_1,
    SCHEME_THREE_WIRE_2,
    SCHEME_FIELDBUS
  } scheme_t;

  // Reported sequencer state, coded for the status output
  typedef enum logic [2:0] {
    switch_on_inhibited_state,
    ready_to_switch_on_state,
    ready_state,
    operation_state,
    normal_stop_state,
    fast_stop_state
  } seq_state_t;

  localparam int DI_W = 3;
  localparam int DI_ENABLE = 0;
  localparam int DI_CMD_A = 1;
  localparam int DI_CMD_B = 2;
  localparam int SYNC_W = 2;

  // Fieldbus control word bit positions
  localparam int CW_W = 16;
  localparam int CW_ON = 0;
  localparam int CW_NO_COAST = 1;
  localparam int CW_NO_QUICK = 2;
  localparam int CW_OP_ENABLE = 3;
  localparam int CW_REVERSE = 11;

  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_CW = 2'h1;
  localparam logic [1:0] CMD_CCW = 2'h2;

endpackage

/* core/motor_switch_sequencer.sv */
`timescale 1ns/10ps
module motor_switch_sequencer
  import motor_seq_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Configuration
  input wire scheme_t scheme_in,
  input wire logic auto_start_in,
  input wire logic di_op_enable_in,
  // Commands from pins and fieldbus
  input wire logic [DI_W-1:0] di_in,
  input wire logic di_coast_stop_n_in,
  input wire logic di_quick_stop_n_in,
  input wire logic [CW_W-1:0] ctrl_word_in,
  // Motor control path
  input wire logic zero_speed_in,
  // Status and motor control
  output seq_state_t state_out,
  output logic energise_out,
  output logic ramp_down_out,
  output logic quick_ramp_out,
  output logic reverse_out
);

  motor_cmd_if cmd_bus ();

  logic [DI_W-1:0] di_sync;
  logic [1:0] stop_n_sync;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic boot_ff;
  logic energise_ff;
  logic ramp_down_ff;
  logic quick_ramp_ff;
  logic reverse_ff;
  logic coast;
  logic quick;
  logic run;

  motor_input_sync #(.WIDTH(DI_W)) u_di_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(di_in),
    .sync_out(di_sync)
  );

  // Stop inputs reset low, so they read as active until synchronised
  motor_input_sync #(.WIDTH(2)) u_stop_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in({di_coast_stop_n_in, di_quick_stop_n_in}),
    .sync_out(stop_n_sync)
  );

  motor_cmd_decode u_decode (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .scheme_in(scheme_in),
    .di_op_enable_in(di_op_enable_in),
    .zero_speed_in(zero_speed_in),
    .di_in(di_sync),
    .ctrl_word_in(ctrl_word_in),
    .di_coast_stop_n_in(stop_n_sync[1]),
    .di_quick_stop_n_in(stop_n_sync[0]),
    .cmd(cmd_bus.src)
  );

  assign coast = cmd_bus.coast_stop;
  assign quick = cmd_bus.quick_stop && !coast;
  assign run = cmd_bus.run;

  // First evaluation after reset, once synchronisers have settled
  logic [SYNC_W-1:0] settle_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      settle_ff <= '0;
      boot_ff <= 1'b1;
    end else if (ce_in) begin
      settle_ff <= {settle_ff[SYNC_W-2:0], 1'b1};
      if (settle_ff[SYNC_W-1]) begin
        boot_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      switch_on_inhibited_state: begin
        if (boot_ff) begin
          nxt_state = switch_on_inhibited_state;
        end else if (coast || quick) begin
          nxt_state = switch_on_inhibited_state;
        end else if (settle_ff[SYNC_W-1] && !run) begin
          nxt_state = ready_to_switch_on_state;
        end
      end
      ready_to_switch_on_state: begin
        if (coast || quick) begin
          nxt_state = switch_on_inhibited_state;
        end else if (run) begin
          nxt_state = ready_state;
        end
      end
      ready_state: begin
        if (coast || quick) begin
          nxt_state = switch_on_inhibited_state;
        end else if (!run) begin
          nxt_state = ready_to_switch_on_state;
        end else if (cmd_bus.op_enable) begin
          nxt_state = operation_state;
        end
      end
      operation_state: begin
        if (coast) begin
          nxt_state = switch_on_inhibited_state;
        end else if (quick) begin
          nxt_state = fast_stop_state;
        end else if (!run || !cmd_bus.op_enable) begin
          nxt_state = normal_stop_state;
        end
      end
      normal_stop_state: begin
        if (coast) begin
          nxt_state = switch_on_inhibited_state;
        end else if (quick) begin
          nxt_state = fast_stop_state;
        end else if (zero_speed_in) begin
          nxt_state = ready_to_switch_on_state;
        end
      end
      fast_stop_state: begin
        if (coast || zero_speed_in) begin
          nxt_state = switch_on_inhibited_state;
        end
      end
      default: begin
        nxt_state = switch_on_inhibited_state;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= switch_on_inhibited_state;
    end else if (ce_in) begin
      if (boot_ff && settle_ff[SYNC_W-1]) begin
        // Switch-on present at power-up inhibits unless auto start
        state_ff <= (run && !auto_start_in) ? switch_on_inhibited_state
                  : ((coast || quick) ? switch_on_inhibited_state
                  : (run ? ready_state : ready_to_switch_on_state));
      end else if (!boot_ff) begin
        state_ff <= nxt_state;
      end
    end
  end

  // Outputs registered from the next state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      energise_ff <= 1'b0;
      ramp_down_ff <= 1'b0;
      quick_ramp_ff <= 1'b0;
      reverse_ff <= 1'b0;
    end else if (ce_in) begin
      energise_ff <= (nxt_state == operation_state) || (nxt_state == normal_stop_state)
        || (nxt_state == fast_stop_state);
      ramp_down_ff <= (nxt_state == normal_stop_state);
      quick_ramp_ff <= (nxt_state == fast_stop_state);
      if (nxt_state == operation_state) begin
        reverse_ff <= cmd_bus.reverse;
      end
    end
  end

  assign state_out = state_ff;
  assign energise_out = energise_ff && !boot_ff;
  assign ramp_down_out = ramp_down_ff;
  assign quick_ramp_out = quick_ramp_ff;
  assign reverse_out = reverse_ff;

  a_coast_deenergise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !boot_ff && coast |=> !energise_ff)
    else $error("Motor still energised after coast stop");
  a_inhibit_ignores_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !boot_ff && state_ff == switch_on_inhibited_state |=>
    state_ff != ready_state && state_ff != operation_state)
    else $error("Switch-on taken while inhibited");
  a_stop_inhibits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !boot_ff && (coast || quick) && state_ff != operation_state
    && state_ff != normal_stop_state && state_ff != fast_stop_state
    |=> state_ff == switch_on_inhibited_state)
    else $error("Stop command did not inhibit");
  a_ready_waits_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == ready_state && !cmd_bus.op_enable |=> state_ff != operation_state)
    else $error("Operation entered without enable");
  a_quick_fast_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == operation_state && quick |=> state_ff == fast_stop_state
    ##0 quick_ramp_ff)
    else $error("Quick stop did not enter fast stop");
  a_ramp_normal_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == operation_state && !coast && !quick && !run
    |=> state_ff == normal_stop_state && ramp_down_ff && energise_ff)
    else $error("Ramp stop did not report normal stop");
  a_normal_stop_report: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_ff == normal_stop_state |-> ramp_down_ff && !quick_ramp_ff)
    else $error("Normal stop not reported");
  a_zero_ends_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == normal_stop_state && zero_speed_in && !coast && !quick
    |=> state_ff == ready_to_switch_on_state && !energise_ff)
    else $error("Standstill did not end normal stop");
  a_coast_priority: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == operation_state && coast && cmd_bus.quick_stop
    |=> state_ff == switch_on_inhibited_state)
    else $error("Coast stop lost priority");
  a_enter_operation: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == ready_state && run && cmd_bus.op_enable && !coast && !quick
    |=> state_ff == operation_state && energise_ff)
    else $error("Operation not entered");
  a_boot_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && boot_ff && settle_ff[SYNC_W-1] && !run && !coast && !quick
    |=> state_ff == ready_to_switch_on_state)
    else $error("Boot did not reach ready to switch on");
  a_boot_inhibit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && boot_ff && settle_ff[SYNC_W-1] && run && !auto_start_in
    |=> state_ff == switch_on_inhibited_state)
    else $error("Switch-on at boot did not inhibit");
  a_auto_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && boot_ff && settle_ff[SYNC_W-1] && run && auto_start_in && !coast && !quick
    |=> state_ff == ready_state)
    else $error("Automatic start inhibited at boot");
  a_fast_stop_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == fast_stop_state && zero_speed_in
    |=> state_ff == switch_on_inhibited_state && !energise_ff)
    else $error("Standstill did not end fast stop");
  a_quick_over_ramp: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && state_ff == normal_stop_state && quick |=> state_ff == fast_stop_state)
    else $error("Quick stop lost priority over ramp stop");
  a_fast_stop_report: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_ff == fast_stop_state |-> quick_ramp_ff && !ramp_down_ff)
    else $error("Fast stop not reported");
  a_operation_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_ff == operation_state |-> energise_ff && !ramp_down_ff && !quick_ramp_ff)
    else $error("Motor not energised in operation");

  c_operation: cover property (@(posedge clk_in) state_ff == operation_state);
  c_normal_stop: cover property (@(posedge clk_in) state_ff == normal_stop_state);
  c_fast_stop: cover property (@(posedge clk_in) state_ff == fast_stop_state);
  c_auto_start: cover property (@(posedge clk_in)
    $fell(boot_ff) && state_ff == ready_state);
  c_boot_inhibit: cover property (@(posedge clk_in)
    $fell(boot_ff) && state_ff == switch_on_inhibited_state);

endmodule
